/* File: hw/ssbh_pkg.sv */
/*
 * Constants and types of the slave status block handler.
 * Assumes a 16-bit image word and two master ports of 256 slaves each.
 */
package ssbh_pkg;

  // ****************************************************************
  // Block codes.
  // ****************************************************************
  localparam logic [15:0] CODE_DIS_P1    = 16'h0BB8; // Disable, port 1.
  localparam logic [15:0] CODE_EN_P1     = 16'h0BB9; // Enable, port 1.
  localparam logic [15:0] CODE_STAT_P1_F = 16'h0BBA; // First status slice.
  localparam logic [15:0] CODE_STAT_P1_L = 16'h0BBE; // Last status slice.
  localparam logic [15:0] CODE_P2_BASE   = 16'h0C1C; // First port 2 code.
  localparam logic [15:0] CODE_P2_OFS    = 16'h0064; // Port 2 code offset.

  // ****************************************************************
  // Block layout.
  // ****************************************************************
  localparam logic [7:0] W_CODE      = 8'h00; // Block code word.
  localparam logic [7:0] W_ID        = 8'h01; // Count or next block id.
  localparam logic [7:0] W_DATA      = 8'h02; // First payload word.
  localparam logic [7:0] W_DATA_LAST = 8'h3D; // Last slice or address word.
  localparam logic [9:0] SLICE_LEN   = 10'h03C; // Slaves in one slice.
  localparam logic [9:0] N_SLAVES    = 10'h100; // Slaves per port.
  localparam logic [7:0] MAX_ADDR    = 8'hFF;   // Highest slave address.

  // Block transfer sizes, selected by a two-bit configuration code.
  localparam logic [1:0] BTS_SEL_60  = 2'h0;
  localparam logic [1:0] BTS_SEL_120 = 2'h1;
  localparam logic [7:0] BTS_60      = 8'h3C;
  localparam logic [7:0] BTS_120     = 8'h78;
  localparam logic [7:0] BTS_240     = 8'hF0;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [1:0] {
    SLV_IDLE     = 2'b00,
    SLV_ACTIVE   = 2'b01,
    SLV_SUSPEND  = 2'b10,
    SLV_DISABLED = 2'b11
  } ssbh_slv_t;

  typedef enum logic [1:0] {
    EVT_INIT = 2'b00,
    EVT_FAIL = 2'b01,
    EVT_SCAN = 2'b10
  } ssbh_evt_t;

  typedef enum logic [1:0] {
    BLK_NONE = 2'b00,
    BLK_DIS  = 2'b01,
    BLK_EN   = 2'b10,
    BLK_STAT = 2'b11
  } ssbh_blk_t;

  typedef enum logic {
    ST_RX = 1'b0,
    ST_TX = 1'b1
  } ssbh_fsm_t;

endpackage : ssbh_pkg

/* File: hw/ssbh_table.sv */
/*
 * Slave state and suspend counter table for two ports.
 * Assumes one write per cycle; reads are combinational.
 */
`timescale 1ns/1ns
`default_nettype none
module ssbh_table #(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Table access.
  ssbh_tbl_if.store tif
);
  import ssbh_pkg::*;

  ssbh_slv_t        state_mem [512];
  logic [CNT_W-1:0] cnt_mem   [512];

  // ****************************************************************
  // Reads.
  // ****************************************************************
  assign tif.rd_state = state_mem[{tif.rd_port, tif.rd_addr}];
  assign tif.rd_cnt   = cnt_mem[{tif.rd_port, tif.rd_addr}];
  assign tif.q_state  = state_mem[{tif.q_port, tif.q_addr}];

  // ****************************************************************
  // Writes.
  // ****************************************************************
  // Every slave starts out not defined, with a cleared counter.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 512; i++) begin
        state_mem[i] <= SLV_IDLE;
        cnt_mem[i]   <= '0;
      end
    end else if (tif.wr_en) begin
      state_mem[{tif.wr_port, tif.wr_addr}] <= tif.wr_state;
      cnt_mem[{tif.wr_port, tif.wr_addr}]   <= tif.wr_cnt;
    end
  end

endmodule : ssbh_table
`default_nettype wire

/* File: hw/ssbh_tbl_if.sv */
/*
 * Access bundle between the handler and its slave state table.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface ssbh_tbl_if #(parameter int CNT_W = 16);
  import ssbh_pkg::*;
  // Shared read port.
  logic             rd_port;
  logic [7:0]       rd_addr;
  ssbh_slv_t        rd_state;
  logic [CNT_W-1:0] rd_cnt;
  // Write port.
  logic             wr_en;
  logic             wr_port;
  logic [7:0]       wr_addr;
  ssbh_slv_t        wr_state;
  logic [CNT_W-1:0] wr_cnt;
  // Polling query port.
  logic             q_port;
  logic [7:0]       q_addr;
  ssbh_slv_t        q_state;

  modport user (output rd_port, rd_addr, wr_en, wr_port, wr_addr,
                output wr_state, wr_cnt, q_port, q_addr,
                input rd_state, rd_cnt, q_state);
  modport store (input rd_port, rd_addr, wr_en, wr_port, wr_addr,
                 input wr_state, wr_cnt, q_port, q_addr,
                 output rd_state, rd_cnt, q_state);
endinterface : ssbh_tbl_if
`default_nettype wire

/* File: hw/ssbh_top.sv */
/*
 * Slave status block handler: keeps per-slave states for two master
 * ports and answers status, disable and enable image blocks.
 * Assumes the output image arrives one word per cycle with its index,
 * and that all inputs come from logic on mclk.
 */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - State 0 means the slave is not in the command list.
// - State 2 means failed; polling stops for a number of scans.
// - State 3 means disabled by the host until it is cleared.
// - List initialisation puts each listed slave in state 1.
// - Exhausted retries set state 2 and load the suspend count.
// - Each scan hit counts a suspended slave down; zero gives state 1.
// - Codes 3002-3006 and 3102-3106 pick five slices of each port.
// - Status answer: code, next block id, then 60 slave states (16 in the fifth slice, zeros after).
// - Codes 3000 and 3100 disable the listed slaves of a port.
// - Disable or enable answer: code, block id, slaves acted on.
// - Codes 3001 and 3101 enable the listed slaves of a port.
// - Answers span the configured 60, 120 or 240 word size plus two words.
// - Special answers interrupt the normal block rotation.
// - 3000 codes serve port 1 and 3100 codes serve port 2.
module ssbh_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Configuration.
  input  wire logic [CNT_W-1:0] suspend_scans,
  input  wire logic [1:0]       cfg_bts,
  input  wire logic [15:0]      next_requested_out_block,
  // Command list events.
  input  wire logic             evt_valid,
  output logic                  evt_ready,
  input  wire ssbh_pkg::ssbh_evt_t evt_kind,
  input  wire logic             evt_port,
  input  wire logic [7:0]       evt_addr,
  // Polling query.
  input  wire logic             poll_port,
  input  wire logic [7:0]       poll_addr,
  output logic                  poll_allowed,
  // Output image words from the host.
  input  wire logic             blk_valid,
  output logic                  blk_ready,
  input  wire logic [7:0]       blk_idx,
  input  wire logic [15:0]      blk_data,
  input  wire logic             blk_last,
  // Input image words to the host.
  output logic                  rsp_valid,
  input  wire logic             rsp_ready,
  output logic [7:0]            rsp_idx,
  output logic [15:0]           rsp_data,
  output logic                  rsp_last,
  output logic                  special_busy
);
  import ssbh_pkg::*;

  // ****************************************************************
  // Decoding.
  // ****************************************************************
  // Folds a port 2 code onto port 1 and classifies it.
  function automatic ssbh_blk_t blk_kind(input logic [15:0] c);
    logic [15:0] lc;
    lc = (c >= CODE_P2_BASE) ? c - CODE_P2_OFS : c;
    if (lc == CODE_DIS_P1) begin
      blk_kind = BLK_DIS;
    end else if (lc == CODE_EN_P1) begin
      blk_kind = BLK_EN;
    end else if (lc >= CODE_STAT_P1_F && lc <= CODE_STAT_P1_L) begin
      blk_kind = BLK_STAT;
    end else begin
      blk_kind = BLK_NONE;
    end
  endfunction : blk_kind

  function automatic logic [7:0] bts_words(input logic [1:0] s);
    if (s == BTS_SEL_60) begin
      bts_words = BTS_60;
    end else if (s == BTS_SEL_120) begin
      bts_words = BTS_120;
    end else begin
      bts_words = BTS_240;
    end
  endfunction : bts_words

  // ****************************************************************
  // State.
  // ****************************************************************
  ssbh_fsm_t   fsm, next_fsm;
  logic [15:0] code, next_code;
  logic [15:0] count, next_count;
  logic [7:0]  nproc, next_nproc;
  logic [15:0] req_id, next_req_id;
  logic        next_rsp_valid;
  logic [7:0]  next_rsp_idx;
  logic [15:0] next_rsp_data;
  logic        next_rsp_last;

  ssbh_tbl_if #(.CNT_W(CNT_W)) tif ();

  ssbh_table #(.CNT_W(CNT_W)) u_table (
    .mclk  (mclk),
    .rst_b (rst_b),
    .tif   (tif)
  );

  logic [15:0] cur_code;
  ssbh_blk_t   cur_kind;
  logic        cur_port;
  logic [2:0]  slice;
  logic [7:0]  tx_nidx;
  logic [9:0]  slot;
  logic [7:0]  last_idx;
  logic        addr_word;

  assign cur_code  = (blk_idx == W_CODE) ? blk_data : code;
  assign cur_kind  = blk_kind(cur_code);
  assign cur_port  = (code >= CODE_P2_BASE);
  assign slice     = 3'(code - (cur_port ? CODE_STAT_P1_F + CODE_P2_OFS
                                         : CODE_STAT_P1_F));
  assign tx_nidx   = rsp_idx + 8'h01;
  assign slot      = 10'(slice) * SLICE_LEN + 10'(tx_nidx) - 10'(W_DATA);
  assign last_idx  = bts_words(cfg_bts) + 8'h01;
  // Address words lie within the field and within the host's count.
  assign addr_word = blk_idx >= W_DATA && blk_idx <= W_DATA_LAST &&
                     {8'h00, blk_idx - W_DATA} < count;

  // Handshakes: host words while idle, events only when no word waits.
  assign blk_ready    = (fsm == ST_RX);
  assign evt_ready    = (fsm == ST_RX) && !blk_valid;
  assign special_busy = (fsm == ST_TX);

  // Polling is allowed only for active slaves.
  assign tif.q_port   = poll_port;
  assign tif.q_addr   = poll_addr;
  assign poll_allowed = (tif.q_state == SLV_ACTIVE);

  // ****************************************************************
  // Next state.
  // ****************************************************************
  // Receives blocks, applies events and builds answers word by word.
  always_comb begin
    next_fsm       = fsm;
    next_code      = code;
    next_count     = count;
    next_nproc     = nproc;
    next_req_id    = req_id;
    next_rsp_valid = rsp_valid;
    next_rsp_idx   = rsp_idx;
    next_rsp_data  = rsp_data;
    next_rsp_last  = rsp_last;
    tif.rd_port    = evt_port;
    tif.rd_addr    = evt_addr;
    tif.wr_en      = 1'b0;
    tif.wr_port    = evt_port;
    tif.wr_addr    = evt_addr;
    tif.wr_state   = SLV_ACTIVE;
    tif.wr_cnt     = '0;
    case (fsm)
      ST_RX: begin
        if (blk_valid) begin
          if (blk_idx == W_CODE) begin
            next_code  = blk_data;
            next_nproc = 8'h00;
            next_count = 16'h0000;
          end
          if (blk_idx == W_ID) begin
            next_count = blk_data;
          end
          if ((cur_kind == BLK_DIS || cur_kind == BLK_EN) && addr_word &&
              blk_data <= {8'h00, MAX_ADDR}) begin
            tif.wr_en    = 1'b1;
            tif.wr_port  = cur_port;
            tif.wr_addr  = blk_data[7:0];
            tif.wr_state = (cur_kind == BLK_DIS) ? SLV_DISABLED
                                                 : SLV_ACTIVE;
            next_nproc   = nproc + 8'h01;
          end
          if (blk_last && cur_kind != BLK_NONE) begin
            next_fsm       = ST_TX;
            next_code      = cur_code;
            next_req_id    = next_requested_out_block;
            next_rsp_valid = 1'b1;
            next_rsp_idx   = W_CODE;
            next_rsp_data  = cur_code;
            next_rsp_last  = 1'b0;
          end
        end else if (evt_valid) begin
          tif.wr_en = 1'b1;
          case (evt_kind)
            EVT_INIT: begin
              tif.wr_state = SLV_ACTIVE;
            end
            EVT_FAIL: begin
              tif.wr_state = SLV_SUSPEND;
              tif.wr_cnt   = suspend_scans;
            end
            default: begin
              tif.wr_en = (tif.rd_state == SLV_SUSPEND);
              if (tif.rd_cnt > CNT_W'(1)) begin
                tif.wr_state = SLV_SUSPEND;
                tif.wr_cnt   = tif.rd_cnt - CNT_W'(1);
              end
            end
          endcase
        end
      end
      default: begin
        tif.rd_port = cur_port;
        tif.rd_addr = slot[7:0];
        if (rsp_ready) begin
          if (rsp_last) begin
            next_fsm       = ST_RX;
            next_rsp_valid = 1'b0;
          end else begin
            next_rsp_idx  = tx_nidx;
            next_rsp_last = (tx_nidx == last_idx);
            next_rsp_data = 16'h0000;
            if (tx_nidx == W_ID) begin
              next_rsp_data = req_id;
            end else if (blk_kind(code) == BLK_STAT) begin
              if (tx_nidx <= W_DATA_LAST && slot < N_SLAVES) begin
                next_rsp_data = {14'h0000, tif.rd_state};
              end
            end else if (tx_nidx == W_DATA) begin
              next_rsp_data = {8'h00, nproc};
            end
          end
        end
      end
    endcase
  end

  // Registers the handler state.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fsm       <= ST_RX;
      code      <= 16'h0000;
      count     <= 16'h0000;
      nproc     <= 8'h00;
      req_id    <= 16'h0000;
      rsp_valid <= 1'b0;
      rsp_idx   <= 8'h00;
      rsp_data  <= 16'h0000;
      rsp_last  <= 1'b0;
    end else begin
      fsm       <= next_fsm;
      code      <= next_code;
      count     <= next_count;
      nproc     <= next_nproc;
      req_id    <= next_req_id;
      rsp_valid <= next_rsp_valid;
      rsp_idx   <= next_rsp_idx;
      rsp_data  <= next_rsp_data;
      rsp_last  <= next_rsp_last;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_evt(ssbh_evt_t k);
    evt_valid && evt_ready && evt_kind == k;
  endsequence
  sequence s_special_end;
    blk_valid && blk_ready && blk_last && cur_kind != BLK_NONE;
  endsequence

  property p_fail_load;
    s_evt(EVT_FAIL) |-> tif.wr_en && tif.wr_state == SLV_SUSPEND &&
                        tif.wr_cnt == suspend_scans;
  endproperty
  a_fail_load: assert property (p_fail_load)
    else $error("Failure did not suspend the slave.");

  property p_scan_release;
    s_evt(EVT_SCAN) && tif.rd_state == SLV_SUSPEND && tif.rd_cnt <= 1
      |-> tif.wr_en && tif.wr_state == SLV_ACTIVE;
  endproperty
  a_scan_release: assert property (p_scan_release)
    else $error("Expired suspend did not restore the slave.");

  property p_scan_dec;
    s_evt(EVT_SCAN) && tif.rd_state == SLV_SUSPEND && tif.rd_cnt > 1
      |-> tif.wr_cnt == tif.rd_cnt - 1 && tif.wr_state == SLV_SUSPEND;
  endproperty
  a_scan_dec: assert property (p_scan_dec)
    else $error("Suspend counter did not step down by one.");

  property p_init;
    s_evt(EVT_INIT) |-> tif.wr_en && tif.wr_state == SLV_ACTIVE;
  endproperty
  a_init: assert property (p_init)
    else $error("Initialised slave not made active.");

  property p_high_addr;
    blk_valid && blk_ready && blk_data > 16'h00FF |-> !tif.wr_en;
  endproperty
  a_high_addr: assert property (p_high_addr)
    else $error("Out of range slave address was applied.");

  property p_disable;
    blk_valid && tif.wr_en && cur_kind == BLK_DIS
      |=> tif.q_addr != $past(tif.wr_addr) ||
          tif.q_port != $past(tif.wr_port) || !poll_allowed;
  endproperty
  a_disable: assert property (p_disable)
    else $error("Disabled slave still allowed to poll.");

  property p_answer_start;
    s_special_end ##1 1'b1 |-> rsp_valid && rsp_idx == 8'h00 &&
                               rsp_data == code && special_busy;
  endproperty
  a_answer_start: assert property (p_answer_start)
    else $error("Answer did not open with the received code.");

  property p_answer_id;
    rsp_valid && rsp_idx == W_ID |-> rsp_data == req_id;
  endproperty
  a_answer_id: assert property (p_answer_id)
    else $error("Second answer word is not the next block id.");

  property p_answer_len;
    rsp_valid && rsp_last |-> rsp_idx == last_idx;
  endproperty
  a_answer_len: assert property (p_answer_len)
    else $error("Answer length does not match the block size.");

  property p_count_bound;
    rsp_valid && rsp_idx == W_DATA && blk_kind(code) != BLK_STAT
      |-> {8'h00, rsp_data[7:0]} <= count && rsp_data <= 16'd60;
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("Processed count exceeds the allowed entries.");

endmodule : ssbh_top
`default_nettype wire

/* File: test/ssbh_host_model.sv */
/*
 * Host model: sends output image blocks word by word and collects the
 * answer block. Assumes the bench clock; drives at falling edges.
 */
`timescale 1ns/1ns
`default_nettype none
module ssbh_host_model (
  // Clock.
  input  wire logic        mclk,
  // Output image words.
  output var  logic        blk_valid,
  input  wire logic        blk_ready,
  output var  logic [7:0]  blk_idx,
  output var  logic [15:0] blk_data,
  output var  logic        blk_last,
  // Input image words.
  input  wire logic        rsp_valid,
  output var  logic        rsp_ready,
  input  wire logic [7:0]  rsp_idx,
  input  wire logic [15:0] rsp_data,
  input  wire logic        rsp_last
);
  // ****************************************************************
  // Block store and transfer.
  // ****************************************************************
  logic [15:0] img [0:241];
  logic [15:0] ans [0:241];
  int          ans_n;

  // Lines start idle.
  initial begin
    blk_valid = 1'b0;
    blk_idx = 8'h00;
    blk_data = 16'h0000;
    blk_last = 1'b0;
    rsp_ready = 1'b0;
  end

  // Sends nw words, then takes answer words, stalling when slow is set.
  task automatic xfer(input int nw, input bit slow, input bit want,
                      output bit ok);
    int t;
    bit done;
    ok = 1'b1;
    done = 1'b0;
    ans_n = 0;
    foreach (ans[i]) ans[i] = 'x;
    // Code first, then count and addresses, rest spare.
    for (int i = 0; i < nw; i++) begin
      @(negedge mclk);
      blk_valid = 1'b1;
      blk_idx = 8'(i);
      blk_data = img[i];
      blk_last = (i == nw - 1);
      t = 0;
      do begin
        @(posedge mclk);
        t++;
      end while (!blk_ready && t < 100);
      if (!blk_ready) ok = 1'b0;
    end
    // Released lines show the inverted last word, not the last word.
    @(negedge mclk);
    blk_valid = 1'b0;
    blk_last = 1'b0;
    blk_data = ~blk_data;
    blk_idx = ~blk_idx;
    t = 0;
    while (!done && t < (want ? 3000 : 20)) begin
      rsp_ready = slow ? t[1] : 1'b1;
      @(posedge mclk);
      if (rsp_valid && rsp_ready) begin
        ans[rsp_idx] = rsp_data;
        ans_n++;
        done = rsp_last;
      end
      @(negedge mclk);
      t++;
    end
    if (want && !done) ok = 1'b0;
  endtask : xfer
endmodule : ssbh_host_model
`default_nettype wire

/* File: test/testbench.sv */
/*
 * Self-checking bench of the slave status block handler.
 * Assumes the host model beside it; keeps its own slave state table.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  err_count++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import ssbh_pkg::*;
  // ****************************************************************
  // Signals and expected table.
  // ****************************************************************
  logic        mclk = 1'b0;
  logic        rst_b, evt_valid, evt_ready, evt_port, poll_port;
  logic        poll_allowed, blk_valid, blk_ready, blk_last;
  logic        rsp_valid, rsp_ready, rsp_last, special_busy;
  logic [15:0] suspend_scans, nrob, blk_data, rsp_data;
  logic [1:0]  cfg_bts;
  logic [7:0]  evt_addr, poll_addr, blk_idx, rsp_idx;
  ssbh_evt_t   evt_kind;
  ssbh_slv_t   st [2][256];
  int          cnt [2][256];
  int          err_count, samples_checked, seed;

  // Clock of 4 ns period.
  always #2 mclk = ~mclk;

  ssbh_top #(.CNT_W(16)) i_dut (.mclk(mclk), .rst_b(rst_b),
    .suspend_scans(suspend_scans), .cfg_bts(cfg_bts),
    .next_requested_out_block(nrob), .evt_valid(evt_valid),
    .evt_ready(evt_ready), .evt_kind(evt_kind), .evt_port(evt_port),
    .evt_addr(evt_addr), .poll_port(poll_port), .poll_addr(poll_addr),
    .poll_allowed(poll_allowed), .blk_valid(blk_valid),
    .blk_ready(blk_ready), .blk_idx(blk_idx), .blk_data(blk_data),
    .blk_last(blk_last), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_idx(rsp_idx), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .special_busy(special_busy));

  ssbh_host_model i_host (.mclk(mclk), .blk_valid(blk_valid),
    .blk_ready(blk_ready), .blk_idx(blk_idx), .blk_data(blk_data),
    .blk_last(blk_last), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_idx(rsp_idx), .rsp_data(rsp_data), .rsp_last(rsp_last));

  // ****************************************************************
  // Tasks.
  // ****************************************************************
  // Prints the verdict and ends the run.
  task automatic print_verdict;
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Offers one event, leaves it raised, and updates the expected table.
  task automatic evt(input ssbh_evt_t k, input logic p, input logic [7:0] a);
    int t;
    @(negedge mclk);
    evt_valid = 1'b1;
    evt_kind = k;
    evt_port = p;
    evt_addr = a;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (!evt_ready && t < 50);
    if (!evt_ready) begin
      err_count++;
      print_verdict();
    end
    if (k == EVT_INIT) st[p][a] = SLV_ACTIVE;
    else if (k == EVT_FAIL) begin
      st[p][a] = SLV_SUSPEND;
      cnt[p][a] = (suspend_scans == 0) ? 1 : int'(suspend_scans);
    end else if (st[p][a] == SLV_SUSPEND) begin
      if (cnt[p][a] <= 1) st[p][a] = SLV_ACTIVE;
      else cnt[p][a]--;
    end
  endtask : evt

  // Drops any event and checks the polling answer of one slave.
  task automatic poll(input logic p, input logic [7:0] a);
    @(negedge mclk);
    evt_valid = 1'b0;
    poll_port = p;
    poll_addr = a;
    #1;
    `CHK("poll_allowed", st[p][a] == SLV_ACTIVE, poll_allowed)
  endtask : poll

  // Sends one block of the configured size and checks the answer.
  task automatic special(input logic [15:0] code, input bit slow);
    int sz, p, k, n;
    bit ok, ctl, stat;
    logic [15:0] e;
    sz = (cfg_bts == BTS_SEL_60) ? 60 : (cfg_bts == BTS_SEL_120) ? 120 : 240;
    p = (code >= CODE_P2_BASE);
    k = int'(code) - (p ? 100 : 0) - int'(CODE_DIS_P1);
    ctl = (k == 0 || k == 1);
    stat = (k >= 2 && k <= 6);
    i_host.img[0] = code;
    @(negedge mclk);
    evt_valid = 1'b0;
    nrob = 16'($random(seed));
    i_host.xfer(sz + 1, slow, ctl || stat, ok);
    if (!ok) begin
      err_count++;
      print_verdict();
    end
    n = 0;
    for (int i = 0; ctl && i < sz - 1 && i < 60; i++)
      if (i < int'(i_host.img[1]) && i_host.img[2+i] <= 16'h00FF) begin
        st[p][i_host.img[2+i][7:0]] = k[0] ? SLV_ACTIVE : SLV_DISABLED;
        n++;
      end
    `CHK("answer words", (ctl || stat) ? sz + 2 : 0, i_host.ans_n)
    `CHK("special_busy", 1'b0, special_busy)
    for (int w = 0; w < i_host.ans_n && w < 242; w++) begin
      e = (w == 0) ? code : (w == 1) ? nrob : 16'h0000;
      if (ctl && w == 2) e = 16'(n);
      if (stat && w >= 2 && w <= 61 && (k - 2) * 60 + w - 2 < 256)
        e = 16'(st[p][(k - 2) * 60 + w - 2]);
      if (stat) `CHK("status word", e, i_host.ans[w])
      else `CHK("control word", e, i_host.ans[w])
    end
  endtask : special

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    seed = 11234;
    err_count = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    suspend_scans = 16'h0000;
    cfg_bts = 2'h0;
    nrob = 16'h0000;
    evt_valid = 1'b0;
    evt_kind = EVT_INIT;
    evt_port = 1'b0;
    evt_addr = 8'h00;
    poll_port = 1'b0;
    poll_addr = 8'h00;
    foreach (st[p, a]) st[p][a] = SLV_IDLE;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    special(CODE_STAT_P1_F, 1'b0);
    // List random slaves back to back on both ports.
    repeat (60) evt(EVT_INIT, 1'($random(seed)), 8'($random(seed)));
    poll(1'b1, evt_addr);
    // A failed slave waits out its suspend count; zero acts as one.
    for (int s = 0; s < 4; s++) begin
      suspend_scans = 16'(s);
      evt(EVT_FAIL, s[0], 8'h05);
      poll(s[0], 8'h05);
      repeat (s > 1 ? s : 1) begin
        evt(EVT_SCAN, s[0], 8'h05);
        poll(s[0], 8'h05);
      end
    end
    // Disable then enable lists on both ports, every size, with
    // addresses above 255 and counts beyond the address field.
    for (int c = 0; c < 8; c++) begin
      cfg_bts = 2'(c);
      i_host.img[1] = 16'(c * 9 + 3);
      for (int i = 0; i < 240; i++)
        i_host.img[2+i] = 16'((i * 37 + c) % 256 + ((i % 5 == 1) ? 256 : 0));
      special(CODE_DIS_P1 + 16'(c % 2) + (c[1] ? CODE_P2_OFS : 16'h0000), c[2]);
      poll(c[1], 8'(c));
    end
    // Random mix of events with polling checks in between.
    repeat (300) begin
      suspend_scans <= 16'($random(seed)) & 16'h0003;
      evt(ssbh_evt_t'(2'({$random(seed)} % 3)), 1'($random(seed)),
          8'({$random(seed)} % 8));
      if ($random(seed) & 1) poll(evt_port, evt_addr);
    end
    // Every status slice of both ports, stalling on alternate slices.
    for (int c = 0; c < 10; c++) begin
      cfg_bts = 2'(c);
      special(CODE_STAT_P1_F + 16'(c % 5) + (c >= 5 ? CODE_P2_OFS : 16'h0000), c[0]);
    end
    // Codes outside the handled range draw no answer.
    special(16'h03E8, 1'b0);
    special(CODE_STAT_P1_L + 16'h0001, 1'b0);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
